// *** verilog/srcp_pkg.sv ***
package srcp_pkg;
   // ----------------------------------------------------------------
   // clock and line timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10000000;
   localparam int OVS = 16;
   localparam int BAUD_38400 = 38400;
   localparam int BAUD_19200 = 19200;
   localparam int BAUD_9600 = 9600;
   localparam int BAUD_4800 = 4800;
   localparam int BAUD_2400 = 2400;
   localparam int BAUD_1200 = 1200;
   localparam int BAUD_600 = 600;
   localparam int BAUD_300 = 300;
   localparam int MAX_UNITS = 16;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0c;
   localparam logic [7:0] OFS_PROMPT = 8'h10;
   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   localparam int CTL_BAUD = 0;
   localparam int CTL_WORD8 = 3;
   localparam int CTL_PAR = 4;
   localparam int CTL_NOPROMPT = 6;
   localparam int CTL_ECHO = 7;
   localparam int CTL_BINARY = 8;
   localparam int CTL_ADDR = 9;
   localparam logic [2:0] RST_BAUD = 3'h2;
   localparam logic RST_WORD8 = 1'b0;
   localparam logic [1:0] RST_PAR = 2'h1;
   localparam logic RST_ECHO = 1'b1;
   localparam logic [3:0] RST_ADDR = 4'h0;
   // ----------------------------------------------------------------
   // status fields
   // ----------------------------------------------------------------
   localparam int STS_RXV = 0;
   localparam int STS_CMD = 1;
   localparam int STS_TXRDY = 2;
   localparam int STS_SEL = 3;
   localparam int STS_ERR = 4;
   localparam int STS_OVL = 5;
   localparam int STS_UNL = 6;
   // ----------------------------------------------------------------
   // characters
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_QUERY = 8'h3f;
   localparam logic [7:0] CH_STAR = 8'h2a;
   localparam logic [7:0] CH_SEMI = 8'h3b;
   localparam logic [7:0] CH_BSL = 8'h5c;
   localparam logic [7:0] CH_N = 8'h4e;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} srcp_par_t;
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
   } srcp_rxs_t;
   typedef enum logic [2:0] {
      PS_IDLE, PS_BSL, PS_N, PS_ADDR, PS_OTHER
   } srcp_ps_t;
   typedef enum logic [1:0] {PR_NONE, PR_CR, PR_LF, PR_CHAR} srcp_pr_t;

   function automatic int srcp_rate(input logic [2:0] sel);
      case (sel)
         3'h0: return BAUD_38400;
         3'h1: return BAUD_19200;
         3'h2: return BAUD_9600;
         3'h3: return BAUD_4800;
         3'h4: return BAUD_2400;
         3'h5: return BAUD_1200;
         3'h6: return BAUD_600;
         default: return BAUD_300;
      endcase
   endfunction
endpackage

// *** verilog/srcp_port.sv ***
// Function
// - frame: start bit, seven or eight data bits, optional parity, one stop
// - eight selectable bit rates, fastest 38400 bits per second
// - exactly one stop bit sent and expected, never configurable
// - word length seven or eight; parity even, odd or none by software
// - eight-bit words outside binary mode: top bit sent as zero, ignored on receive
// - received parity is never checked; every character is accepted
// - reset configuration: even parity, seven data bits, one stop bit
// - binary dumps carry full bytes, only with eight-bit words
// - one command served at a time; reply on the port it came from
// - no compound commands; a semicolon marks the command as an error
// - auxiliary port chains units, up to sixteen on one host port
// - after reset the main port is active whatever the address
// - select-address command keeps the matching unit, deselects others
// - each byte received while selected is echoed back; host waits for the echo
// - commands end in CR or CR LF; replies end CR LF, or CR alone
// - prompt is a question mark on error, overload or unlock
// - prompt is an asterisk when nothing is wrong
`timescale 1ns/1ps
module srcp_port #(
   parameter int CLK_HZ = srcp_pkg::CLK_HZ
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic main_rxd,
   output logic main_txd,
   input wire logic aux_rxd,
   output logic aux_txd,
   input wire logic overload_in,
   input wire logic unlock_in,
   output logic unit_selected
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      srcp_pkg::srcp_rxs_t st;
      logic [3:0] cnt;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic done;
      logic [7:0] b;
   } srcp_rx_t;

   typedef struct packed {
      logic busy;
      logic [3:0] cnt;
      logic [3:0] left;
      logic [10:0] sh;
      logic line;
   } srcp_tx_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] f1;
      logic [1:0] f2;
      logic [11:0] div;
      logic tick;
      srcp_rx_t [1:0] rx;
      srcp_tx_t [1:0] tx;
      logic [2:0] baud;
      logic word8;
      logic [1:0] par;
      logic noprompt;
      logic echo_en;
      logic binary;
      logic [3:0] addr;
      logic selected;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic cmd_done;
      logic err;
      logic echo_v;
      logic [7:0] echo_b;
      logic resp_v;
      logic [7:0] resp_b;
      srcp_pkg::srcp_pr_t pstep;
      logic perr;
      logic fwd_v;
      logic [7:0] fwd_b;
      logic up_v;
      logic [7:0] up_b;
      srcp_pkg::srcp_ps_t pst;
      logic [4:0] naddr;
      logic ndig;
      logic ack;
      logic [31:0] dat;
   } srcp_state_t;

   srcp_state_t st;
   srcp_state_t next_st;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // truncating divide: 38400 gives 1.7 % fast, within receiver margin
   function automatic logic [11:0] srcp_div(input logic [2:0] sel);
      return 12'(CLK_HZ / (srcp_pkg::OVS * srcp_pkg::srcp_rate(sel)) - 1);
   endfunction

   // data bits as they go on the line
   function automatic logic [7:0] srcp_data(input logic [7:0] b,
                                            input logic w8,
                                            input logic bin);
      return {w8 & bin & b[7], b[6:0]};
   endfunction

   function automatic logic [10:0] srcp_frame(input logic [7:0] d,
                                              input logic w8,
                                              input logic [1:0] par);
      logic p;
      p = (par == srcp_pkg::PAR_ODD) ? ~^d : ^d;
      if (w8 && par != srcp_pkg::PAR_NONE)
         return {1'b1, p, d, 1'b0};
      else if (w8)
         return {2'b11, d, 1'b0};
      else if (par != srcp_pkg::PAR_NONE)
         return {2'b11, p, d[6:0], 1'b0};
      else
         return {3'b111, d[6:0], 1'b0};
   endfunction

   function automatic logic [3:0] srcp_flen(input logic w8,
                                            input logic [1:0] par);
      return 4'd9 + {3'h0, w8} + {3'h0, par != srcp_pkg::PAR_NONE};
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic req;
      logic [7:0] b;
      logic load;
      logic [7:0] lb;
      logic [1:0] line;
      next_st = st;
      req = wb_cyc_i & wb_stb_i & ~st.ack;
      b = 8'h00;
      load = 1'b0;
      lb = 8'h00;
      line = st.s2;
      next_st.s1 = {aux_rxd, main_rxd};
      next_st.s2 = st.s1;
      next_st.f1 = {unlock_in, overload_in};
      next_st.f2 = st.f1;

      // 16x bit clock enable
      next_st.tick = 1'b0;
      if (st.div == 12'h000) begin
         next_st.div = srcp_div(st.baud);
         next_st.tick = 1'b1;
      end else begin
         next_st.div = st.div - 12'h001;
      end

      // receivers, main [0] and auxiliary [1]
      for (int i = 0; i < 2; i++) begin
         next_st.rx[i].done = 1'b0;
         if (st.tick) begin
            next_st.rx[i].cnt = st.rx[i].cnt + 4'h1;
            case (st.rx[i].st)
               srcp_pkg::RX_IDLE: begin
                  next_st.rx[i].cnt = 4'h0;
                  if (!line[i])
                     next_st.rx[i].st = srcp_pkg::RX_START;
               end
               srcp_pkg::RX_START: begin
                  if (st.rx[i].cnt == 4'h7) begin
                     next_st.rx[i].cnt = 4'h0;
                     next_st.rx[i].bitn = 4'h0;
                     // glitch filter: a short low pulse is no start bit
                     next_st.rx[i].st = line[i] ? srcp_pkg::RX_IDLE :
                                                  srcp_pkg::RX_DATA;
                  end
               end
               srcp_pkg::RX_DATA: begin
                  if (st.rx[i].cnt == 4'hf) begin
                     next_st.rx[i].sh = {line[i], st.rx[i].sh[7:1]};
                     next_st.rx[i].bitn = st.rx[i].bitn + 4'h1;
                     if (st.rx[i].bitn == {3'h3, st.word8})
                        next_st.rx[i].st =
                           (st.par == srcp_pkg::PAR_NONE) ?
                           srcp_pkg::RX_STOP : srcp_pkg::RX_PAR;
                  end
               end
               srcp_pkg::RX_PAR: begin
                  if (st.rx[i].cnt == 4'hf)
                     next_st.rx[i].st = srcp_pkg::RX_STOP;
               end
               srcp_pkg::RX_STOP: begin
                  // bad stop bit is not an error either; byte still taken
                  if (st.rx[i].cnt == 4'hf) begin
                     next_st.rx[i].st = srcp_pkg::RX_IDLE;
                     next_st.rx[i].done = 1'b1;
                     next_st.rx[i].b = st.word8 ?
                        srcp_data(st.rx[i].sh, 1'b1, st.binary) :
                        {1'b0, st.rx[i].sh[7:1]};
                  end
               end
               default: next_st.rx[i].st = srcp_pkg::RX_IDLE;
            endcase
         end
      end

      // register bus; clears come before the events below so sets win
      next_st.ack = req;
      next_st.dat = 32'h0000_0000;
      if (req && wb_we_i) begin
         case (wb_adr_i)
            srcp_pkg::OFS_CTRL: begin
               if (wb_sel_i[0]) begin
                  next_st.baud = wb_dat_i[srcp_pkg::CTL_BAUD +: 3];
                  next_st.word8 = wb_dat_i[srcp_pkg::CTL_WORD8];
                  next_st.par = wb_dat_i[srcp_pkg::CTL_PAR +: 2];
                  next_st.noprompt = wb_dat_i[srcp_pkg::CTL_NOPROMPT];
                  next_st.echo_en = wb_dat_i[srcp_pkg::CTL_ECHO];
               end
               if (wb_sel_i[1]) begin
                  next_st.binary = wb_dat_i[srcp_pkg::CTL_BINARY];
                  next_st.addr = wb_dat_i[srcp_pkg::CTL_ADDR +: 4];
               end
            end
            srcp_pkg::OFS_TXDATA: begin
               if (wb_sel_i[0] && !st.resp_v && st.selected) begin
                  next_st.resp_v = 1'b1;
                  next_st.resp_b = wb_dat_i[7:0];
               end
            end
            srcp_pkg::OFS_PROMPT: begin
               if (wb_sel_i[0] && st.pstep == srcp_pkg::PR_NONE &&
                   st.selected) begin
                  next_st.pstep = srcp_pkg::PR_CR;
                  next_st.perr = wb_dat_i[0] | st.err |
                                 st.f2[0] | st.f2[1];
                  next_st.err = 1'b0;
                  next_st.cmd_done = 1'b0;
               end
            end
            default: ;
         endcase
      end else if (req) begin
         case (wb_adr_i)
            srcp_pkg::OFS_CTRL: begin
               next_st.dat[srcp_pkg::CTL_BAUD +: 3] = st.baud;
               next_st.dat[srcp_pkg::CTL_WORD8] = st.word8;
               next_st.dat[srcp_pkg::CTL_PAR +: 2] = st.par;
               next_st.dat[srcp_pkg::CTL_NOPROMPT] = st.noprompt;
               next_st.dat[srcp_pkg::CTL_ECHO] = st.echo_en;
               next_st.dat[srcp_pkg::CTL_BINARY] = st.binary;
               next_st.dat[srcp_pkg::CTL_ADDR +: 4] = st.addr;
            end
            srcp_pkg::OFS_STATUS: begin
               next_st.dat[srcp_pkg::STS_RXV] = st.rx_valid;
               next_st.dat[srcp_pkg::STS_CMD] = st.cmd_done;
               next_st.dat[srcp_pkg::STS_TXRDY] = ~st.resp_v &
                  (st.pstep == srcp_pkg::PR_NONE);
               next_st.dat[srcp_pkg::STS_SEL] = st.selected;
               next_st.dat[srcp_pkg::STS_ERR] = st.err;
               next_st.dat[srcp_pkg::STS_OVL] = st.f2[0];
               next_st.dat[srcp_pkg::STS_UNL] = st.f2[1];
            end
            srcp_pkg::OFS_RXDATA: begin
               next_st.dat[7:0] = st.rx_byte;
               next_st.rx_valid = 1'b0;
            end
            default: ;
         endcase
      end

      // main port byte in
      if (st.rx[0].done) begin
         b = st.rx[0].b;
         // everything goes downstream; only selected units act on it
         if (!st.fwd_v) begin
            next_st.fwd_v = 1'b1;
            next_st.fwd_b = b;
         end
         if (st.selected) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_byte = b;
            if (st.echo_en) begin
               next_st.echo_v = 1'b1;
               next_st.echo_b = b;
            end
            if (b == srcp_pkg::CH_CR)
               next_st.cmd_done = 1'b1;
            if (b == srcp_pkg::CH_SEMI)
               next_st.err = 1'b1;
         end
         // select-address parser runs whether selected or not
         case (st.pst)
            srcp_pkg::PS_IDLE:
               if (b == srcp_pkg::CH_BSL)
                  next_st.pst = srcp_pkg::PS_BSL;
               else if (b != srcp_pkg::CH_LF && b != srcp_pkg::CH_CR)
                  next_st.pst = srcp_pkg::PS_OTHER;
            srcp_pkg::PS_BSL:
               next_st.pst = (b == srcp_pkg::CH_N) ? srcp_pkg::PS_N :
                                                     srcp_pkg::PS_OTHER;
            srcp_pkg::PS_N: begin
               next_st.naddr = 5'h00;
               next_st.ndig = 1'b0;
               next_st.pst = (b == srcp_pkg::CH_SP) ? srcp_pkg::PS_ADDR :
                                                      srcp_pkg::PS_OTHER;
            end
            srcp_pkg::PS_ADDR:
               if (b >= srcp_pkg::CH_0 && b <= srcp_pkg::CH_9) begin
                  next_st.ndig = 1'b1;
                  // values of 20 and up saturate; none from 16 up ever match
                  next_st.naddr = (st.naddr > 5'h01) ? 5'h1f :
                     5'(st.naddr * 4'd10 + b[3:0]);
               end else if (b != srcp_pkg::CH_CR) begin
                  next_st.pst = srcp_pkg::PS_OTHER;
               end
            default: ;
         endcase
         if (b == srcp_pkg::CH_CR) begin
            next_st.pst = srcp_pkg::PS_IDLE;
            if (st.pst == srcp_pkg::PS_ADDR && st.ndig &&
                st.naddr < 5'(srcp_pkg::MAX_UNITS))
               next_st.selected = (st.naddr == {1'b0, st.addr});
         end
      end

      // auxiliary port byte in: replies from downstream units
      if (st.rx[1].done && !st.selected && !st.up_v) begin
         next_st.up_v = 1'b1;
         next_st.up_b = st.rx[1].b;
      end

      // main transmitter source: echo, reply, terminator/prompt, upstream
      if (!st.tx[0].busy) begin
         if (st.echo_v) begin
            load = 1'b1;
            lb = st.echo_b;
            // a byte landing now keeps its own echo pending
            next_st.echo_v = st.rx[0].done & st.selected & st.echo_en;
         end else if (st.resp_v) begin
            load = 1'b1;
            lb = st.resp_b;
            next_st.resp_v = 1'b0;
         end else if (st.pstep != srcp_pkg::PR_NONE) begin
            load = 1'b1;
            case (st.pstep)
               srcp_pkg::PR_CR: begin
                  lb = srcp_pkg::CH_CR;
                  next_st.pstep = st.noprompt ? srcp_pkg::PR_CHAR :
                                                srcp_pkg::PR_LF;
               end
               srcp_pkg::PR_LF: begin
                  lb = srcp_pkg::CH_LF;
                  next_st.pstep = srcp_pkg::PR_CHAR;
               end
               default: begin
                  lb = st.perr ? srcp_pkg::CH_QUERY :
                                 srcp_pkg::CH_STAR;
                  next_st.pstep = srcp_pkg::PR_NONE;
               end
            endcase
         end else if (st.up_v) begin
            load = 1'b1;
            lb = st.up_b;
            next_st.up_v = 1'b0;
         end
      end

      // transmitters
      for (int i = 0; i < 2; i++) begin
         next_st.tx[i].line = st.tx[i].busy ? st.tx[i].sh[0] : 1'b1;
         if (st.tx[i].busy && st.tick) begin
            next_st.tx[i].cnt = st.tx[i].cnt + 4'h1;
            if (st.tx[i].cnt == 4'hf) begin
               next_st.tx[i].sh = {1'b1, st.tx[i].sh[10:1]};
               next_st.tx[i].left = st.tx[i].left - 4'h1;
               if (st.tx[i].left == 4'h1)
                  next_st.tx[i].busy = 1'b0;
            end
         end
      end
      if (!st.tx[1].busy && st.fwd_v) begin
         next_st.fwd_v = 1'b0;
         next_st.tx[1].busy = 1'b1;
         next_st.tx[1].cnt = 4'h0;
         next_st.tx[1].left = srcp_flen(st.word8, st.par);
         next_st.tx[1].sh = srcp_frame(
            srcp_data(st.fwd_b, st.word8, st.binary), st.word8, st.par);
      end
      if (load) begin
         next_st.tx[0].busy = 1'b1;
         next_st.tx[0].cnt = 4'h0;
         next_st.tx[0].left = srcp_flen(st.word8, st.par);
         next_st.tx[0].sh = srcp_frame(
            srcp_data(lb, st.word8, st.binary), st.word8, st.par);
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.s1 <= 2'h3;
         st.s2 <= 2'h3;
         st.tx[0].line <= 1'b1;
         st.tx[1].line <= 1'b1;
         st.baud <= srcp_pkg::RST_BAUD;
         st.word8 <= srcp_pkg::RST_WORD8;
         st.par <= srcp_pkg::RST_PAR;
         st.echo_en <= srcp_pkg::RST_ECHO;
         st.addr <= srcp_pkg::RST_ADDR;
         st.selected <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign main_txd = st.tx[0].line;
   assign aux_txd = st.tx[1].line;
   assign unit_selected = st.selected;
endmodule // srcp_port

// *** bench/srcp_host.sv ***
`timescale 1ns/1ps
module srcp_host #(
   parameter int BIT = 256
) (
   input wire logic clk,
   output logic rxd,
   input wire logic txd
);
   // ---------------------------
   // host side of a link; also stands in for the downstream unit on the auxiliary link
   // ---------------------------
   logic [7:0] q[$];
   logic [7:0] b;
   initial rxd = 1'b1;
   task automatic bitw(input logic v);
      rxd <= v;
      repeat (BIT) @(posedge clk);
   endtask
   // same rate, 7 bits, even parity as the device
   task automatic send(input logic [7:0] c);
      @(posedge clk);
      bitw(1'b0);
      for (int i = 0; i < 7; i++) bitw(c[i]);
      bitw(^c[6:0]);
      bitw(1'b1); // single stop
   endtask
   // bytes kept for the bench, which waits for each echo
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      b = 8'h0;
      for (int i = 0; i < 7; i++) begin
         repeat (BIT) @(posedge clk);
         b[i] = txd;
      end
      repeat (2 * BIT) @(posedge clk);
      q.push_back(b);
   end
endmodule // srcp_host

// *** bench/srcp_port_chk.sv ***
`timescale 1ns/1ps
module srcp_port_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic main_txd,
   input wire logic aux_txd,
   input wire logic unit_selected
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_rst_vals: assert property ($past(sys_rst) |-> unit_selected
      && main_txd && aux_txd && !wb_ack_o) else $error("bad reset state");
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_unmap_zero: assert property (wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) > 8'h10 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_sts_sel: assert property (wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == 8'h04 |-> wb_dat_o[3] == $past(unit_selected))
      else $error("status select bit wrong");
   a_main_start: assert property ($fell(main_txd) |-> !main_txd[*8])
      else $error("short start bit main");
   a_aux_start: assert property ($fell(aux_txd) |-> !aux_txd[*8])
      else $error("short start bit aux");
endmodule // srcp_port_chk
bind srcp_port srcp_port_chk i_chk (.clk(clk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .main_txd(main_txd), .aux_txd(aux_txd), .unit_selected(unit_selected));

// *** bench/srcp_port_tb_top.sv ***
`timescale 1ns/1ps
module srcp_port_tb_top;
   // ---------------------------
   // bench
   // ---------------------------
   logic clk, sys_rst, cyc, stb, we, ack, rxd, txd, ovl, sel_o;
   logic unl, axd, atx;
   logic [7:0] adr;
   logic [31:0] dat, dq, r;
   logic [7:0] b;
   int error_cnt = 0;
   int n_checks = 0;
   srcp_port i_srcp_port (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
      .wb_dat_i(dat), .wb_dat_o(dq), .wb_ack_o(ack), .main_rxd(rxd),
      .main_txd(txd), .aux_rxd(axd), .aux_txd(atx), .overload_in(ovl),
      .unlock_in(unl), .unit_selected(sel_o));
   srcp_host i_srcp_host (.clk(clk), .rxd(rxd), .txd(txd));
   srcp_host i_srcp_host_aux (.clk(clk), .rxd(axd), .txd(atx));
   always #50 clk = ~clk;
   task automatic end_sim;
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // waits for ack, takes data at that same edge
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
      q = dq;
      {cyc, stb} <= 2'b00;
      chk("bus ack", {31'h0, ack}, 32'h1);
   endtask
   task automatic rxb(output logic [7:0] c);
      int n = 0;
      while (i_srcp_host.q.size() == 0 && n++ < 40000) @(posedge clk);
      c = (i_srcp_host.q.size() > 0) ? i_srcp_host.q.pop_front() : 8'hxx;
   endtask
   // forwarded copy lands with the echo; one edge settles the race
   task automatic fwd(input logic [7:0] c);
      @(posedge clk);
      b = (i_srcp_host_aux.q.size() > 0) ?
         i_srcp_host_aux.q.pop_front() : 8'hxx;
      chk("forward", b, c);
   endtask
   task automatic prm(input logic [7:0] c);
      wb(1'b1, 8'h10, 32'h0, r);
      rxb(b);
      chk("prompt cr", b, 8'h0d);
      rxb(b);
      chk("prompt lf", b, 8'h0a);
      rxb(b);
      chk("prompt char", b, c);
   endtask
   task automatic t_reset;
      wb(1'b0, 8'h00, 32'h0, r);
      chk("ctrl reset", r, 32'h92);
      wb(1'b0, 8'h20, 32'h0, r);
      chk("unmapped", r, 32'h0);
      chk("selected", sel_o, 32'h1);
      wb(1'b1, 8'h00, 32'h90, r); // fastest rate
   endtask
   task automatic t_echo;
      i_srcp_host.send(8'h41);
      rxb(b);
      chk("echo", b, 8'h41);
      fwd(8'h41);
      wb(1'b0, 8'h08, 32'h0, r);
      chk("rxdata", r, 32'h41);
   endtask
   task automatic t_prompt;
      i_srcp_host.send(8'h0d);
      rxb(b);
      chk("cr echo", b, 8'h0d);
      wb(1'b0, 8'h04, 32'h0, r);
      chk("cmd flag", r[1], 32'h1);
      prm(8'h2a);
      ovl <= 1'b1;
      repeat (4) @(posedge clk);
      prm(8'h3f);
      ovl <= 1'b0;
      unl <= 1'b1;
      repeat (4) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0, r);
      chk("unlock flag", r[6], 32'h1);
      unl <= 1'b0;
      i_srcp_host.send(8'h3b);
      rxb(b);
      chk("semi echo", b, 8'h3b);
      i_srcp_host.send(8'h0d);
      rxb(b);
      chk("cr echo", b, 8'h0d);
      wb(1'b0, 8'h04, 32'h0, r);
      chk("semi flag", r[4], 32'h1);
      wb(1'b1, 8'h00, 32'hd0, r); // noprompt on
      wb(1'b1, 8'h10, 32'h0, r);
      rxb(b);
      chk("short cr", b, 8'h0d);
      rxb(b);
      chk("semi prompt", b, 8'h3f);
      wb(1'b1, 8'h00, 32'h90, r);
   endtask
   task automatic t_select;
      logic [7:0] s[4] = '{8'h5c, 8'h4e, 8'h20, 8'h33};
      foreach (s[i]) begin
         i_srcp_host.send(s[i]);
         rxb(b);
         chk("select echo", b, s[i]);
      end
      i_srcp_host.send(8'h0d);
      repeat (3000) @(posedge clk);
      chk("deselected", sel_o, 32'h0);
      i_srcp_host.q.delete();
      i_srcp_host_aux.q.delete();
      i_srcp_host.send(8'h41);
      repeat (3000) @(posedge clk);
      chk("no echo", 32'(i_srcp_host.q.size()), 32'h0);
      fwd(8'h41);
      i_srcp_host_aux.send(8'h52);
      rxb(b);
      chk("relay", b, 8'h52);
   endtask
   initial begin
      {clk, sys_rst, cyc, stb, we, ovl, unl, adr, dat} = {2'b01, 45'h0};
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_echo;
      t_prompt;
      t_select;
      end_sim;
   end
   // limit above the roughly 75k cycles the sequence needs, under 100k
   initial begin
      repeat (96000) @(posedge clk);
      error_cnt++;
      end_sim;
   end
endmodule // srcp_port_tb_top
